// ---- design/sram_port_regs.vh ----
// Function
// - Capture full address on qualified rising edge
// - Each byte select writes its byte and parity
// - Write strobe sampled only with qualifier low
// - Advance high increments internal burst counter
// - Advance low loads fresh external start address
// - Edges count only while clock qualifier low
// - Selected: select one low, two high, three low
// - Select two active high, combined with others
// - Output enable high three-states data pins
// - No drive on write data, after deselect
// - Qualifier high stretches cycle, holds all state but the strap capture
// - Burst-order strap: high interleaved, low linear
// - Read data from output register, previous edge
`ifndef SRAM_PORT_REGS_VH
`define SRAM_PORT_REGS_VH

`define ADDR_W 19
`define UPPER_W 17
`define BURST_W 2
`define LANES 4
`define BYTE_W 8
`define LANE_W 9
`define DATA_W 32
`define DEPTH 524288
`define BURST_ZERO 2'h0
`define BURST_ONE 2'h1
`define ORDER_INTERLEAVED 1'h1
`define ORDER_LINEAR 1'h0

`endif

// ---- design/pipelined_sync_sram_port.v ----
`timescale 1ns/1ns
`include "sram_port_regs.vh"

module pipelined_sync_sram_port (
   // Clock and reset
   input wire ref_clk_in,
   input wire rst_in,
   // Address
   input wire [`UPPER_W-1:0] addr_upper_in,
   input wire burst_addr_bit_zero_in,
   input wire burst_addr_bit_one_in,
   // Control
   input wire [`LANES-1:0] byte_lane_write_n_in,
   input wire write_n_in,
   input wire advance_or_load_in,
   input wire clock_qualifier_n_in,
   input wire chip_select_one_n_in,
   input wire chip_select_two_in,
   input wire chip_select_three_n_in,
   input wire output_enable_n_in,
   input wire burst_order_strap_in,
   // Data and parity lanes, pin input side
   input wire [`DATA_W-1:0] data_in,
   input wire [`LANES-1:0] parity_lane_in,
   // Data and parity lanes, pin output side
   output wire [`DATA_W-1:0] data_out,
   output wire [`LANES-1:0] parity_lane_out,
   output wire data_oe_n_out
);

   reg order_ff;
   reg strap_taken_ff;
   reg sel_ff;
   reg wr_ff;
   reg [`UPPER_W-1:0] upper_ff;
   reg [`BURST_W-1:0] start_ff;
   reg [`BURST_W-1:0] count_ff;
   reg act_ff;
   reg act_wr_ff;
   reg [`ADDR_W-1:0] act_addr_ff;
   reg [`LANES-1:0] act_lane_wr_n_ff;
   reg drive_ff;
   wire [`LANES*`LANE_W-1:0] lane_q;

   reg nxt_sel_ff;
   reg nxt_wr_ff;
   reg [`UPPER_W-1:0] nxt_upper_ff;
   reg [`BURST_W-1:0] nxt_start_ff;
   reg [`BURST_W-1:0] nxt_count_ff;
   reg [`BURST_W-1:0] low_addr;

   wire edge_ok = ~clock_qualifier_n_in;
   wire cs_hit = ~chip_select_one_n_in & chip_select_two_in & ~chip_select_three_n_in;

   // Strap caught once, on the first edge after reset release
   // burst order strap
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         strap_taken_ff <= 1'b0;
         order_ff <= `ORDER_INTERLEAVED;
      end else if (!strap_taken_ff) begin
         strap_taken_ff <= 1'b1;
         order_ff <= burst_order_strap_in;
      end
   end

   always @* begin
      nxt_sel_ff = sel_ff;
      nxt_wr_ff = wr_ff;
      nxt_upper_ff = upper_ff;
      nxt_start_ff = start_ff;
      nxt_count_ff = count_ff;
      if (!advance_or_load_in) begin
         nxt_sel_ff = cs_hit;
         nxt_wr_ff = ~write_n_in;
         nxt_upper_ff = addr_upper_in;
         nxt_start_ff = {burst_addr_bit_one_in, burst_addr_bit_zero_in};
         nxt_count_ff = `BURST_ZERO;
      end else begin
         nxt_count_ff = count_ff + `BURST_ONE;
      end
      if (order_ff == `ORDER_INTERLEAVED) begin
         low_addr = nxt_start_ff ^ nxt_count_ff;
      end else begin
         low_addr = nxt_start_ff + nxt_count_ff;
      end
   end

   // Address/control stage; a high qualifier freezes everything
   // stretch the cycle
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         sel_ff <= 1'b0;
         wr_ff <= 1'b0;
         upper_ff <= {`UPPER_W{1'b0}};
         start_ff <= `BURST_ZERO;
         count_ff <= `BURST_ZERO;
         act_ff <= 1'b0;
         act_wr_ff <= 1'b0;
         act_addr_ff <= {`ADDR_W{1'b0}};
         act_lane_wr_n_ff <= {`LANES{1'b1}};
      end else if (edge_ok) begin
         sel_ff <= nxt_sel_ff;
         wr_ff <= nxt_wr_ff;
         upper_ff <= nxt_upper_ff;
         start_ff <= nxt_start_ff;
         count_ff <= nxt_count_ff;
         act_ff <= nxt_sel_ff;
         act_wr_ff <= nxt_wr_ff;
         act_addr_ff <= {nxt_upper_ff, low_addr};
         act_lane_wr_n_ff <= byte_lane_write_n_in | {`LANES{~nxt_wr_ff}};
      end
   end

   // Data stage: write data taken, or read data registered out
   // drive only after a selected read
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         drive_ff <= 1'b0;
      end else if (edge_ok) begin
         drive_ff <= act_ff & ~act_wr_ff;
      end
   end

   // Lane zero: bits 7..0 and parity bit zero
   sram_lane lane_zero (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .edge_ok_in(edge_ok),
      .act_in(act_ff),
      .read_in(~act_wr_ff),
      .write_n_in(act_lane_wr_n_ff[0]),
      .addr_in(act_addr_ff),
      .lane_in({parity_lane_in[0], data_in[7:0]}),
      .lane_out(lane_q[8:0])
   );

   // Lane one: bits 15..8 and parity bit one
   sram_lane lane_one (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .edge_ok_in(edge_ok),
      .act_in(act_ff),
      .read_in(~act_wr_ff),
      .write_n_in(act_lane_wr_n_ff[1]),
      .addr_in(act_addr_ff),
      .lane_in({parity_lane_in[1], data_in[15:8]}),
      .lane_out(lane_q[17:9])
   );

   // Lane two: bits 23..16 and parity bit two
   sram_lane lane_two (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .edge_ok_in(edge_ok),
      .act_in(act_ff),
      .read_in(~act_wr_ff),
      .write_n_in(act_lane_wr_n_ff[2]),
      .addr_in(act_addr_ff),
      .lane_in({parity_lane_in[2], data_in[23:16]}),
      .lane_out(lane_q[26:18])
   );

   // Lane three: bits 31..24 and parity bit three
   sram_lane lane_three (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .edge_ok_in(edge_ok),
      .act_in(act_ff),
      .read_in(~act_wr_ff),
      .write_n_in(act_lane_wr_n_ff[3]),
      .addr_in(act_addr_ff),
      .lane_in({parity_lane_in[3], data_in[31:24]}),
      .lane_out(lane_q[35:27])
   );

   assign data_out = {lane_q[34:27], lane_q[25:18], lane_q[16:9], lane_q[7:0]};
   assign parity_lane_out = {lane_q[35], lane_q[26], lane_q[17], lane_q[8]};

   // Output enable is asynchronous, so this one gate sits after the flop
   // drive gating
   assign data_oe_n_out = ~(drive_ff & ~output_enable_n_in);

endmodule

// One byte lane with its parity bit: storage and output register
module sram_lane (
   // Clock and reset
   input wire ref_clk_in,
   input wire rst_in,
   // Controls of the access in the data phase
   input wire edge_ok_in,
   input wire act_in,
   input wire read_in,
   input wire write_n_in,
   input wire [`ADDR_W-1:0] addr_in,
   // Lane pins
   input wire [`LANE_W-1:0] lane_in,
   output wire [`LANE_W-1:0] lane_out
);

   reg [`LANE_W-1:0] mem [0:`DEPTH-1];
   reg [`LANE_W-1:0] lane_ff;

   always @(posedge ref_clk_in) begin
      if (!rst_in && edge_ok_in && act_in && !write_n_in) begin
         mem[addr_in] <= lane_in;
      end
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         lane_ff <= {`LANE_W{1'b0}};
      end else if (edge_ok_in && act_in && read_in) begin
         lane_ff <= mem[addr_in];
      end
   end

   assign lane_out = lane_ff;

endmodule

// ---- bench/sram_port_sva.sv ----
`timescale 1ns/1ns
`include "sram_port_regs.vh"
module sram_port_sva (
   input wire ref_clk_in,
   input wire rst_in,
   input wire write_n_in,
   input wire advance_or_load_in,
   input wire clock_qualifier_n_in,
   input wire chip_select_one_n_in,
   input wire chip_select_two_in,
   input wire chip_select_three_n_in,
   input wire output_enable_n_in,
   input wire [`DATA_W-1:0] data_out,
   input wire [`LANES-1:0] parity_lane_out,
   input wire data_oe_n_out
);
   wire q = !clock_qualifier_n_in;
   wire sel = !chip_select_one_n_in && chip_select_two_in && !chip_select_three_n_in;
   wire ld = q && !advance_or_load_in;
   wire rd = ld && sel && write_n_in;
   wire off = ld && !(sel && write_n_in);
   wire av = q && advance_or_load_in;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   oe_mask_a: assert property (output_enable_n_in |-> data_oe_n_out)
      else $error("drive with enable high");
   desel_off_a: assert property (off ##1 q |=> data_oe_n_out)
      else $error("drive after write or deselect");
   read_drive_a: assert property (rd ##1 q |=> !output_enable_n_in |-> !data_oe_n_out)
      else $error("no drive after read");
   burst_read_a: assert property (rd ##1 av ##1 q |=> !output_enable_n_in |-> !data_oe_n_out)
      else $error("no drive on burst beat");
   desel_adv_a: assert property ((ld && !sel) ##1 av ##1 q |=> data_oe_n_out)
      else $error("advance left deselect");
   stall_data_a: assert property (clock_qualifier_n_in |=> $stable({parity_lane_out, data_out}))
      else $error("data moved on masked edge");
   stall_drive_a: assert property (clock_qualifier_n_in ##1 $stable(output_enable_n_in) |-> $stable(data_oe_n_out))
      else $error("drive moved on masked edge");
   reset_idle_a: assert property (disable iff (1'b0) rst_in |=> data_oe_n_out && data_out == 0)
      else $error("outputs not idle in reset");
   cover property (rd ##1 av);
   cover property (off && !write_n_in);
   cover property (clock_qualifier_n_in [*2]);
endmodule
bind pipelined_sync_sram_port sram_port_sva chk (.*);

// ---- bench/ctl_bus_model.sv ----
`timescale 1ns/1ns
module ctl_bus_model (
   input wire ref_clk_in,
   input wire drv_in,
   input wire [35:0] bus_in,
   input wire [35:0] dut_in,
   input wire oe_n_in,
   output wire [35:0] pin_out
);
   reg [35:0] last_ff = 36'h0;
   assign pin_out = !oe_n_in ? dut_in : drv_in ? bus_in : ~last_ff;
   always @(posedge ref_clk_in) last_ff <= pin_out;
endmodule

// ---- bench/pipelined_sync_sram_port_bench.sv ----
`timescale 1ns/1ns
module pipelined_sync_sram_port_bench;
   reg ref_clk_in = 0, rst_in = 1, c = 1, w = 1, a = 0, q = 0, drv = 0;
   reg c2 = 1, c3 = 0, oe = 0, st = 1;
   reg [3:0] l = 4'hF;
   reg [18:0] ad = 19'h0;
   reg [35:0] b = 36'h0;
   reg [98:0] rows [0:8];
   wire [35:0] pin, dq;
   wire oe_n;
   integer fails = 0, n_tests = 0, i;
   always #5 ref_clk_in = ~ref_clk_in;
   pipelined_sync_sram_port DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .addr_upper_in(ad[18:2]), .burst_addr_bit_zero_in(ad[0]), .burst_addr_bit_one_in(ad[1]),
      .byte_lane_write_n_in(l), .write_n_in(w), .advance_or_load_in(a),
      .clock_qualifier_n_in(q), .chip_select_one_n_in(c), .chip_select_two_in(c2),
      .chip_select_three_n_in(c3), .output_enable_n_in(oe), .burst_order_strap_in(st),
      .data_in(pin[31:0]), .parity_lane_in(pin[35:32]), .data_out(dq[31:0]),
      .parity_lane_out(dq[35:32]), .data_oe_n_out(oe_n));
   ctl_bus_model PM (.ref_clk_in(ref_clk_in), .drv_in(drv), .bus_in(b), .dut_in(dq),
      .oe_n_in(oe_n), .pin_out(pin));
   task chk(input logic eo, input logic [35:0] ed);
      begin
         n_tests = n_tests + 1;
         if (oe_n !== eo || (!eo && dq !== ed)) begin
            fails = fails + 1;
            $display("[ERR] %0t output mismatch", $time);
         end
      end
   endtask
   task close_out;
      begin
         $display("tests %0d fails %0d", n_tests, fails);
         if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   initial begin
      #2000;
      fails = fails + 1;
      close_out;
   end
   initial begin
      rows[0] = {3'h0, 4'h0, 19'h10, 36'h0, 37'h0};
      rows[1] = {3'h1, 4'h0, 19'h11, 36'h5_1111_1111, 37'h0};
      rows[2] = {3'h0, 4'hE, 19'h11, 36'hF_2222_2222, 37'h0};
      rows[3] = {3'h2, 4'hF, 19'h11, 36'h0_3333_3333, 37'h0};
      rows[4] = {3'h3, 4'hF, 19'h11, 36'h0, 37'h0};
      rows[5] = {3'h6, 4'hF, 19'h0, 36'h0, 1'h1, 36'hE_2222_2233};
      rows[6] = {3'h3, 4'hF, 19'h0, 36'h0, 1'h1, 36'h5_1111_1111};
      rows[7] = {3'h6, 4'hF, 19'h0, 36'h0, 37'h0};
      rows[8] = {3'h6, 4'hF, 19'h0, 36'h0, 37'h0};
      repeat (8) @(posedge ref_clk_in);
      rst_in <= 1'h0;
      #1 chk(1'h1, 36'h0);
      for (i = 0; i < 9; i = i + 1) begin
         @(posedge ref_clk_in);
         {c, w, a, l, ad, b} <= rows[i][98:37];
         drv <= i > 0 && rows[i - 1][98:97] == 2'h0;
         #1 chk(!rows[i][36], rows[i][35:0]);
      end
      @(posedge ref_clk_in);
      {q, c, w, a, ad, l, drv} <= {4'h8, 19'h10, 4'h0, 1'h1};
      repeat (2) @(posedge ref_clk_in);
      {q, w, drv} <= 3'h2;
      #1 chk(1'h1, 36'h0);
      repeat (2) @(posedge ref_clk_in);
      #1 chk(1'h0, 36'h5_1111_1111);
      @(posedge ref_clk_in);
      {oe, c2} <= 2'h2;
      #1 chk(1'h1, 36'h0);
      @(posedge ref_clk_in);
      {oe, c2, c3} <= 3'h3;
      @(posedge ref_clk_in);
      c3 <= 1'h0;
      #1 chk(1'h1, 36'h0);
      @(posedge ref_clk_in);
      {rst_in, st, ad} <= {2'h2, 19'h13};
      #1 chk(1'h1, 36'h0);
      @(posedge ref_clk_in);
      rst_in <= 1'h0;
      #1 chk(1'h1, 36'h0);
      @(posedge ref_clk_in);
      a <= 1'h1;
      repeat (2) @(posedge ref_clk_in);
      #1 chk(1'h0, 36'h5_1111_1111);
      close_out;
   end
endmodule
